/* pkg/pei_pkg.sv */
// Package for the event interrupt and sleep control block.
// Assumes a register port decoded by an upstream management frame engine.
package pei_pkg;
    localparam int          REG_AW            = 5;
    localparam int          REG_DW            = 16;
    localparam int          EVT_N             = 11;
    localparam logic [4:0]  ADDR_IRQ_ENABLE   = 5'h16;
    localparam logic [4:0]  ADDR_IRQ_FLAGS    = 5'h17;
    localparam logic [4:0]  ADDR_FIFO_SLEEP   = 5'h18;
    // Control bit positions in the enable register
    localparam int          BIT_READ_CLEAR    = 14;
    localparam int          BIT_RESETUP       = 11;
    // Event bit positions shared by enable and flag registers
    localparam int          EVT_LINK_UP       = 0;
    localparam int          EVT_REMOTE_FAULT  = 1;
    localparam int          EVT_LINK_DOWN     = 2;
    localparam int          EVT_LP_ACK        = 3;
    localparam int          EVT_PD_FAULT      = 4;
    localparam int          EVT_PAGE_RX       = 5;
    localparam int          EVT_RX_ERROR      = 6;
    localparam int          EVT_JABBER        = 7;
    localparam int          EVT_AN_DONE       = 8;
    localparam int          EVT_SLEEP_ENTER   = 9;
    localparam int          EVT_SLEEP_WAKE    = 10;
    // Fifo and sleep register fields
    localparam int          FIFO_HALF_LSB     = 12;
    localparam int          FIFO_HALF_W       = 4;
    localparam logic [3:0]  FIFO_HALF_RST     = 4'h2;
    localparam logic [3:0]  FIFO_HALF_BIAS    = 4'h3;
    localparam int          BIT_SLEEP_EN      = 8;
    localparam int          BIT_PLL_SLEEP     = 7;
    localparam int          BIT_RX_SLEEP      = 6;
    localparam int          BIT_TX_SLEEP      = 5;
    localparam int          BIT_CDR_SLEEP     = 4;
    localparam logic [15:0] IRQ_ENABLE_RST    = 16'h0000;
    localparam logic [15:0] IRQ_ENABLE_MASK   = 16'hffff;
    localparam logic [15:0] FIFO_SLEEP_MASK   = 16'hf1f0;
    localparam logic [15:0] FIFO_SLEEP_RST    = 16'h2000;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] wdata;
    } pei_req_t;

    typedef struct packed {
        logic pll_off;
        logic rx_off;
        logic tx_off;
        logic cdr_off;
    } pei_pwr_t;
endpackage

/* logic/pei_flag_cell.sv */
// One sticky event flag with write-1 and read clearing.
// Assumes event and condition are synchronous to clk_i.
`timescale 1ns/10ps
module pei_flag_cell (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic event_i,
    input  wire logic cond_i,
    input  wire logic w1c_i,
    input  wire logic rd_clr_i,
    input  wire logic resetup_i,
    output logic      flag_o
);
    logic flag_ff;
    logic nxt_flag;

    always_comb begin
        nxt_flag = flag_ff;
        // RULE_18: clear on read
        if (rd_clr_i) begin
            nxt_flag = 1'b0;
        end
        // RULE_01: write-1 clear, skipped when re-setup is on and the condition is pending
        if (w1c_i) begin
            nxt_flag = 1'b0;
            // RULE_02: pending condition keeps flag
            if (resetup_i && cond_i) begin
                nxt_flag = flag_ff;
            end
        end
        // RULE_20: set wins regardless of enable
        if (event_i) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_o = flag_ff;
endmodule

/* logic/pei_event_ctl.sv */
// Event interrupt enables, flags and deep sleep enables of the PHY.
// Assumes req_i comes decoded from the management frame engine, one cycle per access.
// Behaviour
// RULE_01: Re-setup off: writing 1 to a flag always clears it.
// RULE_02: Re-setup on: write 1 keeps flag while its condition persists.
// RULE_03: Bits 10 and 9 enable and record sleep wake and entry.
// RULE_04: Bit 0 enables and records link up; flag self-clears (here it stays set until a write-1 or read clear).
// RULE_05: Bit 8 enables and records negotiation done; flag resets zero.
// RULE_06: Bit 7 enables and records jabber.
// RULE_07: Bit 6 enables and records receive error.
// RULE_08: Bit 5 enables and records page received.
// RULE_09: Bit 4 enables and records parallel detect fault.
// RULE_10: Bit 3 enables and records link partner acknowledge.
// RULE_11: Bit 2 enables and records link down.
// RULE_12: Bit 1 enables and records remote fault; flag bits 15..11 read zero.
// RULE_13: PLL powers down in deep sleep when its option is set.
// RULE_14: Receive block powers down in deep sleep when its option set.
// RULE_15: Transmit converter powers down in deep sleep when option set.
// RULE_16: Clock recovery powers down in deep sleep when option set.
// RULE_17: Fifo half level is (n+3)*2 bits; field resets to 2.
// RULE_18: Read-clear option makes a flag read clear the flags.
// RULE_19: Interrupt asserts while any enabled flag is set.
// RULE_20: Flags set regardless of their enable bit.
`timescale 1ns/10ps
module pei_event_ctl #(
    parameter int EVT_W = pei_pkg::EVT_N
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire pei_pkg::pei_req_t     req_i,
    output logic [pei_pkg::REG_DW-1:0] rdata_o,
    input  wire logic [EVT_W-1:0]      event_i,
    input  wire logic [EVT_W-1:0]      cond_i,
    input  wire logic                  sleep_active_i,
    output logic                       sleep_enable_o,
    output pei_pkg::pei_pwr_t          pwr_off_o,
    output logic [5:0]                 fifo_half_bits_o,
    output logic                       irq_o
);
    import pei_pkg::*;

    logic [REG_DW-1:0] enable_ff;
    logic [REG_DW-1:0] nxt_enable;
    logic [REG_DW-1:0] fifo_sleep_ff;
    logic [REG_DW-1:0] nxt_fifo_sleep;
    logic [REG_DW-1:0] rdata_ff;
    logic [REG_DW-1:0] nxt_rdata;
    logic [5:0]        half_ff;
    logic [5:0]        nxt_half;
    pei_pwr_t          pwr_ff;
    pei_pwr_t          nxt_pwr;
    logic              irq_ff;
    logic              nxt_irq;
    logic [EVT_W-1:0]  flags;
    logic              flag_wr;
    logic              flag_rd_clr;

    function automatic logic hit(input pei_req_t r, input logic [REG_AW-1:0] a);
        return r.addr == a;
    endfunction

    assign flag_wr     = req_i.wr && hit(req_i, ADDR_IRQ_FLAGS);
    // RULE_18: read of flags clears when enabled
    assign flag_rd_clr = req_i.rd && hit(req_i, ADDR_IRQ_FLAGS) && enable_ff[BIT_READ_CLEAR];

    // One flag cell per event bit
    // RULE_03: sleep wake, entry flags
    // RULE_04: link up flag
    // RULE_05: negotiation done flag
    // RULE_06: jabber flag
    // RULE_07: receive error flag
    // RULE_08: page received flag
    // RULE_09: parallel detect flag
    // RULE_10: partner acknowledge flag
    // RULE_11: link down flag
    // RULE_12: remote fault flag
    for (genvar g = 0; g < EVT_W; g++) begin : g_flag
        pei_flag_cell u_cell (
            .clk_i     (clk_i),
            .rst_n_i   (rst_n_i),
            .event_i   (event_i[g]),
            .cond_i    (cond_i[g]),
            .w1c_i     (flag_wr && req_i.wdata[g]),
            .rd_clr_i  (flag_rd_clr),
            .resetup_i (enable_ff[BIT_RESETUP]),
            .flag_o    (flags[g])
        );
    end

    always_comb begin
        nxt_enable     = enable_ff;
        nxt_fifo_sleep = fifo_sleep_ff;
        if (req_i.wr && hit(req_i, ADDR_IRQ_ENABLE)) begin
            nxt_enable = req_i.wdata & IRQ_ENABLE_MASK;
        end
        if (req_i.wr && hit(req_i, ADDR_FIFO_SLEEP)) begin
            nxt_fifo_sleep = req_i.wdata & FIFO_SLEEP_MASK;
        end
    end

    always_comb begin
        nxt_rdata = rdata_ff;
        if (req_i.rd) begin
            case (req_i.addr)
                ADDR_IRQ_ENABLE: nxt_rdata = enable_ff;
                // RULE_12: upper flag bits read zero
                ADDR_IRQ_FLAGS:  nxt_rdata = {{(REG_DW-EVT_W){1'b0}}, flags};
                ADDR_FIFO_SLEEP: nxt_rdata = fifo_sleep_ff;
                default:         nxt_rdata = '0;
            endcase
        end
    end

    always_comb begin
        // RULE_17: half level from field
        nxt_half = 6'((fifo_sleep_ff[FIFO_HALF_LSB +: FIFO_HALF_W] + FIFO_HALF_BIAS) * 2);
        // RULE_13: PLL sleep gating
        nxt_pwr.pll_off = sleep_active_i && fifo_sleep_ff[BIT_SLEEP_EN] && fifo_sleep_ff[BIT_PLL_SLEEP];
        // RULE_14: receive block gating
        nxt_pwr.rx_off  = sleep_active_i && fifo_sleep_ff[BIT_SLEEP_EN] && fifo_sleep_ff[BIT_RX_SLEEP];
        // RULE_15: transmit converter gating
        nxt_pwr.tx_off  = sleep_active_i && fifo_sleep_ff[BIT_SLEEP_EN] && fifo_sleep_ff[BIT_TX_SLEEP];
        // RULE_16: clock recovery gating
        nxt_pwr.cdr_off = sleep_active_i && fifo_sleep_ff[BIT_SLEEP_EN] && fifo_sleep_ff[BIT_CDR_SLEEP];
        // RULE_19: any enabled flag
        nxt_irq = |(flags & enable_ff[EVT_W-1:0]);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            enable_ff     <= IRQ_ENABLE_RST;
            // RULE_17: field resets to two
            fifo_sleep_ff <= FIFO_SLEEP_RST;
            rdata_ff      <= '0;
            half_ff       <= '0;
            pwr_ff        <= '0;
            irq_ff        <= 1'b0;
        end else begin
            enable_ff     <= nxt_enable;
            fifo_sleep_ff <= nxt_fifo_sleep;
            rdata_ff      <= nxt_rdata;
            half_ff       <= nxt_half;
            pwr_ff        <= nxt_pwr;
            irq_ff        <= nxt_irq;
        end
    end

    assign rdata_o          = rdata_ff;
    assign sleep_enable_o   = fifo_sleep_ff[BIT_SLEEP_EN];
    assign pwr_off_o        = pwr_ff;
    assign fifo_half_bits_o = half_ff;
    assign irq_o            = irq_ff;
endmodule

/* bench/pei_event_ctl_properties.sv */
// Port assertions for the event control block.
// Assumes a bind from the bench top.
`timescale 1ns/10ps
module pei_event_chk
    import pei_pkg::*;
#(parameter int EVT_W = EVT_N) (
    input wire logic             clk_i,
    input wire logic             rst_n_i,
    input wire pei_pkg::pei_req_t req_i,
    input wire logic [15:0]      rdata_o,
    input wire logic [EVT_W-1:0] event_i,
    input wire logic [EVT_W-1:0] cond_i,
    input wire logic             sleep_active_i,
    input wire logic             sleep_enable_o,
    input wire pei_pkg::pei_pwr_t pwr_off_o,
    input wire logic [5:0]       fifo_half_bits_o,
    input wire logic             irq_o
);
    logic [15:0] en_ff;
    logic [15:0] ctl_ff;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            en_ff <= '0;
            ctl_ff <= FIFO_SLEEP_RST;
        end else if (req_i.wr && req_i.addr == ADDR_IRQ_ENABLE) begin
            en_ff <= req_i.wdata;
        end else if (req_i.wr && req_i.addr == ADDR_FIFO_SLEEP) begin
            ctl_ff <= req_i.wdata & FIFO_SLEEP_MASK;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_irq_from_event: assert property (|(event_i & en_ff[EVT_W-1:0]) && !req_i.wr |-> ##2 irq_o)
        else $error("irq missing");
    a_irq_all_masked: assert property ($past(en_ff[EVT_W-1:0]) == '0 |-> !irq_o)
        else $error("irq while masked");
    a_rd_enable_reg: assert property (req_i.rd && req_i.addr == ADDR_IRQ_ENABLE |=> rdata_o == $past(en_ff))
        else $error("enable readback");
    a_flag_reserved_zero: assert property (req_i.rd && req_i.addr == ADDR_IRQ_FLAGS |=>
        rdata_o[15:11] == 5'h0)
        else $error("reserved flag bits");
    a_rd_unmapped_zero: assert property (req_i.rd && !(req_i.addr inside {[5'h16:5'h18]}) |=> rdata_o == '0)
        else $error("unmapped read");
    a_fifo_half_level: assert property ($past(rst_n_i) |->
        fifo_half_bits_o == 6'(($past(ctl_ff[15:12]) + 3) * 2))
        else $error("half level");
    a_power_off_map: assert property ($past(rst_n_i) |->
        pwr_off_o == ({4{$past(ctl_ff[8] & sleep_active_i)}} & $past(ctl_ff[7:4])))
        else $error("power map");
    a_sleep_en_write: assert property (req_i.wr && req_i.addr == ADDR_FIFO_SLEEP |=>
        sleep_enable_o == $past(req_i.wdata[8]))
        else $error("sleep enable");
    c_irq: cover property (irq_o);
    c_pll_off: cover property (pwr_off_o.pll_off);
    c_flag_read: cover property (req_i.rd && req_i.addr == ADDR_IRQ_FLAGS ##1 rdata_o != '0);
endmodule

/* bench/pei_sta_model.sv */
// Station manager model issuing one-cycle register strobes.
// Assumes read data registered on the taking edge, sampled 1 ns after it.
`timescale 1ns/10ps
module pei_sta_model (
    input wire logic        clk_i,
    output pei_pkg::pei_req_t req_o,
    input wire logic [15:0] rdata_i
);
    import pei_pkg::*;
    initial req_o = '0;
    // Idle address and data scrambled, strobes cleared
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1 q = rdata_i;
    endtask
endmodule

/* bench/pei_event_ctl_tb_top.sv */
// Bench top: flag and register model against the block.
// Assumes the station model issues all accesses.
`timescale 1ns/10ps
module pei_event_ctl_tb_top;
    import pei_pkg::*;
    localparam int EVT_W = EVT_N;
    logic clk_i, rst_n_i, sa, slp, irq;
    pei_req_t req;
    pei_pwr_t pwr;
    logic [15:0] rdata;
    logic [10:0] ev, cnd;
    logic [5:0] half;
    logic [31:0] seed;
    int errors, n_tests, cyc, en, ctl, flags;
    pei_event_ctl #(.EVT_W(EVT_W)) pei_event_ctl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .rdata_o(rdata), .event_i(ev), .cond_i(cnd), .sleep_active_i(sa), .sleep_enable_o(slp),
        .pwr_off_o(pwr), .fifo_half_bits_o(half), .irq_o(irq));
    pei_sta_model pei_sta_model_i (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        pei_sta_model_i.xfer(1'b1, a, d, q);
        if (a == ADDR_IRQ_ENABLE) en = d;
        if (a == ADDR_FIFO_SLEEP) ctl = d & FIFO_SLEEP_MASK;
        if (a == ADDR_IRQ_FLAGS) flags &= ~(int'(d) & ~(en[BIT_RESETUP] ? int'(cnd) : 0));
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        pei_sta_model_i.xfer(1'b0, a, 16'h0, q);
        chk("rdata", e, q);
        if (a == ADDR_IRQ_FLAGS && en[BIT_READ_CLEAR]) flags = 0;
    endtask
    task automatic pulse(input int k, input logic [10:0] c);
        @(posedge clk_i);
        ev <= 11'h1 << k;
        cnd <= c;
        @(posedge clk_i);
        ev <= '0;
        flags |= 1 << k;
        @(posedge clk_i);
        #1 chk("irq", 16'(|(en & flags)), 16'(irq));
    endtask
    task automatic print_verdict();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {errors, n_tests, cyc, en, flags} = '0;
        ctl = FIFO_SLEEP_RST;
        seed = 32'h663c;
        {rst_n_i, ev, cnd, sa} = '0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_IRQ_FLAGS, 16'h0);
        rd(ADDR_FIFO_SLEEP, FIFO_SLEEP_RST);
        chk("half", 16'd10, 16'(half));
        rd(5'h19, 16'h0);
        for (int k = 0; k < EVT_W; k++) begin
            wr(ADDR_IRQ_ENABLE, rnd() & 16'hb7ff);
            pulse(k, 11'(rnd()));
            rd(ADDR_IRQ_FLAGS, 16'(flags));
            wr(ADDR_IRQ_FLAGS, 16'h1 << k);
            rd(ADDR_IRQ_FLAGS, 16'(flags));
        end
        wr(ADDR_IRQ_ENABLE, 16'h0820);
        pulse(EVT_PAGE_RX, 11'h020);
        wr(ADDR_IRQ_FLAGS, 16'h0020);
        rd(ADDR_IRQ_FLAGS, 16'(flags));
        rd(ADDR_IRQ_FLAGS, 16'(flags));
        pulse(EVT_JABBER, 11'h0);
        wr(ADDR_IRQ_FLAGS, 16'h00a0);
        rd(ADDR_IRQ_FLAGS, 16'(flags));
        wr(ADDR_IRQ_ENABLE, 16'h4004);
        pulse(EVT_LINK_DOWN, 11'h0);
        rd(ADDR_IRQ_FLAGS, 16'(flags));
        rd(ADDR_IRQ_FLAGS, 16'(flags));
        for (int i = 0; i < 12; i++) begin
            wr(ADDR_FIFO_SLEEP, rnd());
            @(posedge clk_i) sa <= ^rnd();
            rd(ADDR_FIFO_SLEEP, 16'(ctl));
            chk("half", 16'(((ctl >> 12) + 3) * 2), 16'(half));
            chk("pwr", 16'(ctl[8] && sa ? ctl[7:4] : 0), 16'(pwr));
            chk("sleep", 16'(ctl[8]), 16'(slp));
        end
        print_verdict();
    end
endmodule
bind pei_event_ctl pei_event_chk #(.EVT_W(EVT_W)) pei_event_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .event_i(event_i), .cond_i(cond_i), .sleep_active_i(sleep_active_i),
    .sleep_enable_o(sleep_enable_o), .pwr_off_o(pwr_off_o), .fifo_half_bits_o(fifo_half_bits_o), .irq_o(irq_o));
